// >>> logic/sbs_slave.sv
/*
 * sbs_slave: slave port of a synchronous shared bus that feeds a word stream
 * through a 16-word buffer, with a status word and a synchronous bus reset.
 * assumes: the master keeps its side of the handshake and holds bus reset for
 * at least one clock; i_rst is the core's own asynchronous reset.
 */
`timescale 1ns/1ps


module sbs_slave
    import sbs_pkg::*;
(
    input  wire logic                        i_ref_clk,     // bus clock
    input  wire logic                        i_rst,         // core async reset, high
    input  wire logic                        i_bus_rst,     // bus reset, synchronous, high
    input  wire sbs_pkg::sbs_req_type        i_bus,         // master request
    output sbs_pkg::sbs_rsp_type             o_bus,         // slave answer
    input  wire logic                        i_priv_only,   // refuse unprivileged writes
    output logic [sbs_pkg::DAT_W-1:0]        o_stream_data, // drained word
    output logic                             o_stream_last, // last word of a packet
    output logic                             o_stream_valid,// word available
    input  wire logic                        i_stream_ready // consumer takes word
);

    import sbs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DAT_W-1:0]  rd_dat;   // registered read data
        logic [XFER_W-1:0] xfer;     // words accepted
        logic [ERR_W-1:0]  errs;     // error terminations given
    } sbs_st_type;

    sbs_st_type              st_reg;
    sbs_st_type              st_next;
    sbs_term_type            term;
    logic                    sel_act;
    logic                    push;
    logic                    fifo_ready;
    logic [FIFO_CNT_W-1:0]   fifo_cnt;
    logic [STREAM_W-1:0]     fifo_out;
    logic [STREAM_W-1:0]     fifo_in;
    logic                    hit_data;
    logic                    hit_status;
    logic                    priv_ok;
    logic                    lanes_ok;

    // ------------------------------------------------------------------
    // selection and decode
    // ------------------------------------------------------------------

    // selected only while strobe and cycle are up and no bus reset
    assign sel_act    = i_bus.stb & i_bus.cyc & ~i_bus_rst;
    // word address compare over bits 31..2
    assign hit_data   = (i_bus.adr == ADR_DATA);
    assign hit_status = (i_bus.adr == ADR_STATUS);
    // address tag only looked at inside a strobe
    assign priv_ok    = ~i_priv_only | i_bus.tga[TGA_PRIV_BIT];
    // push port needs every byte lane valid
    assign lanes_ok   = (i_bus.sel == SEL_ALL);

    // termination choice, one code so only one terminator can rise
    always_comb
    begin
        term = TERM_NONE;
        if (sel_act)
        begin
            if (i_bus.we)
            begin
                if (!hit_data || !lanes_ok || !priv_ok)
                    term = TERM_ERR;
                else if (!fifo_ready)
                    term = TERM_RTY;
                else
                    term = TERM_ACK;
            end
            else
            begin
                if (hit_status)
                    term = TERM_ACK;
                else
                    term = TERM_ERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // answer outputs
    // ------------------------------------------------------------------

    // combinational from strobe, so they drop with it
    assign o_bus.ack = (term == TERM_ACK);
    assign o_bus.err = (term == TERM_ERR);
    assign o_bus.rty = (term == TERM_RTY);
    // registered status word, meaningful only under a terminator
    assign o_bus.dat = st_reg.rd_dat;

    // ------------------------------------------------------------------
    // buffer fill side
    // ------------------------------------------------------------------

    // push only on an acknowledged write
    assign push    = (term == TERM_ACK) & i_bus.we;
    // cycle tag held with the word, qualified by the cycle input
    assign fifo_in = {i_bus.cyc & i_bus.tgc[TGC_LAST_BIT], i_bus.dat};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    // counters and read data, forced to the start values under bus reset
    always_comb
    begin
        st_next        = st_reg;
        st_next.rd_dat = RST_DAT;
        st_next.rd_dat[ST_CNT_LSB +: FIFO_CNT_W] = fifo_cnt;
        st_next.rd_dat[ST_FULL_BIT]  = ~fifo_ready;
        st_next.rd_dat[ST_EMPTY_BIT] = (fifo_cnt == '0);
        st_next.rd_dat[ST_ERR_LSB +: ERR_W]   = st_reg.errs;
        st_next.rd_dat[ST_XFER_LSB +: XFER_W] = st_reg.xfer;
        if (push)
            st_next.xfer = XFER_W'(st_reg.xfer + 1'b1);
        if (term == TERM_ERR)
            st_next.errs = ERR_W'(st_reg.errs + 1'b1);
        if (i_bus_rst)
        begin
            st_next.rd_dat = RST_DAT;
            st_next.xfer   = RST_XFER;
            st_next.errs   = RST_ERR;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // async reset is the core's own; bus reset acts through st_next
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // word buffer
    // ------------------------------------------------------------------

    // bus reset empties the buffer at the same edge as the counters
    sbs_fifo #(
        .WIDTH (STREAM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_flush   (i_bus_rst),
        .i_data    (fifo_in),
        .i_valid   (push),
        .o_ready   (fifo_ready),
        .o_data    (fifo_out),
        .o_valid   (o_stream_valid),
        .i_ready   (i_stream_ready),
        .o_count   (fifo_cnt)
    );

    // drain side straight from the buffer storage
    assign o_stream_data = fifo_out[DAT_W-1:0];
    assign o_stream_last = fifo_out[DAT_W];

endmodule

// >>> shared/sbs_pkg.sv
/*
 * sbs_pkg: constants, carriers and address map of the shared-bus slave port.
 * assumes: one clock, 32-bit data port with byte granularity, word addresses.
 */
package sbs_pkg;

    // ------------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------------
    localparam int DAT_W      = 32;                 // data port width
    localparam int SEL_W      = DAT_W / 8;          // one select per byte lane
    localparam int ADR_LO     = 2;                  // lowest address bit of a 32-bit port
    localparam int ADR_HI     = 31;                 // highest address bit of this core
    localparam int TGA_W      = 2;                  // address tag width
    localparam int TGC_W      = 2;                  // cycle tag width

    // ------------------------------------------------------------------
    // word address map (address bits ADR_HI..ADR_LO)
    // ------------------------------------------------------------------
    localparam logic [ADR_HI:ADR_LO] ADR_DATA   = 30'h0000_0000; // write-only push port
    localparam logic [ADR_HI:ADR_LO] ADR_STATUS = 30'h0000_0001; // read-only status word

    // ------------------------------------------------------------------
    // tag fields
    // ------------------------------------------------------------------
    localparam int TGA_PRIV_BIT = 0;                // address tag: privileged access
    localparam int TGC_LAST_BIT = 0;                // cycle tag: last word of a packet

    // ------------------------------------------------------------------
    // buffer and status layout
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH   = 16;
    localparam int FIFO_CNT_W   = $clog2(FIFO_DEPTH) + 1;
    localparam int STREAM_W     = DAT_W + 1;        // data plus last-word marker
    localparam int XFER_W       = 16;
    localparam int ERR_W        = 8;
    localparam int ST_CNT_LSB   = 0;                // fill level
    localparam int ST_FULL_BIT  = 5;
    localparam int ST_EMPTY_BIT = 6;
    localparam int ST_ERR_LSB   = 8;                // error terminations seen
    localparam int ST_XFER_LSB  = 16;               // words accepted

    // ------------------------------------------------------------------
    // reset values and the all-lanes select mask
    // ------------------------------------------------------------------
    localparam logic [DAT_W-1:0]  RST_DAT  = 32'h0000_0000;
    localparam logic [XFER_W-1:0] RST_XFER = 16'h0000;
    localparam logic [ERR_W-1:0]  RST_ERR  = 8'h00;
    localparam logic [SEL_W-1:0]  SEL_ALL  = 4'hf;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADR_HI:ADR_LO] adr;
        logic [DAT_W-1:0]     dat;
        logic [SEL_W-1:0]     sel;
        logic                 we;
        logic                 cyc;
        logic                 stb;
        logic [TGA_W-1:0]     tga;
        logic [TGC_W-1:0]     tgc;
    } sbs_req_type;

    typedef struct packed {
        logic             ack;
        logic             err;
        logic             rty;
        logic [DAT_W-1:0] dat;
    } sbs_rsp_type;

    typedef enum logic [1:0] {
        TERM_NONE = 2'b00,
        TERM_ACK  = 2'b01,
        TERM_ERR  = 2'b10,
        TERM_RTY  = 2'b11
    } sbs_term_type;

endpackage

// >>> logic/sbs_fifo.sv
/*
 * sbs_fifo: synchronous buffer with valid/ready on both sides and a flush.
 * assumes: one clock; flush is synchronous and wins over push and pop.
 */
`timescale 1ns/1ps

module sbs_fifo #(
    parameter int WIDTH = 33,                          // word width
    parameter int DEPTH = 16                           // words held
) (
    input  wire logic                       i_ref_clk, // clock
    input  wire logic                       i_rst,     // async reset, high
    input  wire logic                       i_flush,   // sync empty
    input  wire logic [WIDTH-1:0]           i_data,    // fill data
    input  wire logic                       i_valid,   // fill valid
    output logic                            o_ready,   // room for a word
    output logic [WIDTH-1:0]                o_data,    // drain data
    output logic                            o_valid,   // word available
    input  wire logic                       i_ready,   // drain accepts
    output logic [$clog2(DEPTH):0]          o_count    // fill level
);

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0]   cnt;
    } fifo_st_type;

    fifo_st_type      st_reg;
    fifo_st_type      st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // handshakes: full and empty from the count
    assign o_ready = (st_reg.cnt != (PW+1)'(DEPTH));
    assign o_valid = (st_reg.cnt != '0);
    assign o_data  = mem[st_reg.rd];
    assign o_count = st_reg.cnt;
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    // pointer and count update
    always_comb
    begin
        st_next = st_reg;
        if (i_flush)
        begin
            st_next = '0;
        end
        else
        begin
            if (push)
                st_next.wr = PW'(st_reg.wr + 1'b1);
            if (pop)
                st_next.rd = PW'(st_reg.rd + 1'b1);
            if (push & ~pop)
                st_next.cnt = (PW+1)'(st_reg.cnt + 1'b1);
            else if (pop & ~push)
                st_next.cnt = (PW+1)'(st_reg.cnt - 1'b1);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // storage carries no reset
    always_ff @(posedge i_ref_clk)
    begin
        if (push & ~i_flush)
            mem[st_reg.wr] <= i_data;
    end

endmodule

// >>> test/sbs_slave_properties.sv
/*
 * sbs_slave_properties: bus port checks bound to sbs_slave.
 * assumes: one clock; i_rst (async, high) disables every check.
 */
`timescale 1ns/1ps

module sbs_slave_properties
    import sbs_pkg::*;
(
    input wire logic                      i_ref_clk,      // bus clock
    input wire logic                      i_rst,          // core reset
    input wire logic                      i_bus_rst,      // bus reset
    input wire sbs_pkg::sbs_req_type      i_bus,          // request
    input wire sbs_pkg::sbs_rsp_type      o_bus,          // answer
    input wire logic                      i_priv_only,    // privilege mode
    input wire logic [sbs_pkg::DAT_W-1:0] o_stream_data,  // head word
    input wire logic                      o_stream_last,  // head marker
    input wire logic                      o_stream_valid, // word ready
    input wire logic                      i_stream_ready  // consumer takes
);
    logic [2:0] term;
    logic       req;

    // terminators and a qualified request
    assign term = {o_bus.ack, o_bus.err, o_bus.rty};
    assign req  = i_bus.stb & i_bus.cyc & ~i_bus_rst;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    one_term_a: assert property ($onehot0(term))
        else $error("several terminators at once");
    idle_quiet_a: assert property (!i_bus.stb |-> term == 3'b000)
        else $error("terminator without strobe");
    strobe_answer_a: assert property (req |-> $onehot(term))
        else $error("strobe left unanswered");
    bus_rst_quiet_a: assert property (i_bus_rst |=> !o_stream_valid && term == 3'b000)
        else $error("bus reset not honoured");
    rst_data_clear_a: assert property (i_bus_rst |=> o_bus.dat == '0)
        else $error("read data not cleared by bus reset");
    lane_err_a: assert property (req && i_bus.we && i_bus.sel != SEL_ALL |-> o_bus.err)
        else $error("partial lanes not refused");
    priv_err_a: assert property (req && i_bus.we && i_priv_only && !i_bus.tga[TGA_PRIV_BIT] |-> o_bus.err)
        else $error("unprivileged write not refused");
    read_map_a: assert property (req && !i_bus.we |-> o_bus.err == (i_bus.adr != ADR_STATUS))
        else $error("read decode wrong");
    push_shows_a: assert property (req && i_bus.we && o_bus.ack |=> o_stream_valid)
        else $error("acknowledged word not buffered");
    head_hold_a: assert property (o_stream_valid && !i_stream_ready && !i_bus_rst
                                  |=> o_stream_valid && $stable(o_stream_data))
        else $error("head word changed unpopped");
endmodule

bind sbs_slave sbs_slave_properties u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus_rst(i_bus_rst),
    .i_bus(i_bus), .o_bus(o_bus), .i_priv_only(i_priv_only), .o_stream_data(o_stream_data),
    .o_stream_last(o_stream_last), .o_stream_valid(o_stream_valid), .i_stream_ready(i_stream_ready));

// >>> test/sbs_master_model.sv
/*
 * sbs_master_model: behavioural bus master, one transfer per call of run.
 * assumes: callers start only after bus reset is released.
 */
`timescale 1ns/1ps

module sbs_master_model
    import sbs_pkg::*;
(
    input  wire logic                 i_ref_clk, // bus clock
    output sbs_pkg::sbs_req_type      o_req,     // request
    input  wire sbs_pkg::sbs_rsp_type i_rsp      // answer
);
    // strobe and cycle stay low until the first call
    initial o_req = '0;

    // hold the request until a terminator is sampled or 40 more cycles pass, then release it
    task automatic run(input logic we, input logic [ADR_HI:ADR_LO] adr, input logic [DAT_W-1:0] dat,
                       input logic [SEL_W-1:0] sel, input logic [TGA_W-1:0] tga, input logic [TGC_W-1:0] tgc,
                       output sbs_term_type term, output logic [DAT_W-1:0] rdat);
        sbs_req_type r;
        int          n;
        n = 0;
        @(posedge i_ref_clk);
        o_req <= '{adr: adr, dat: dat, sel: sel, we: we, cyc: 1'b1, stb: 1'b1, tga: tga, tgc: tgc};
        @(posedge i_ref_clk);
        while (!(i_rsp.ack | i_rsp.err | i_rsp.rty) && n < 40)
        begin
            @(posedge i_ref_clk);
            n++;
        end
        term = i_rsp.rty ? TERM_RTY : (i_rsp.err ? TERM_ERR : (i_rsp.ack ? TERM_ACK : TERM_NONE));
        rdat = i_rsp.dat;
        // released lines show the inverse of their last value, never a stale copy
        r     = ~o_req;
        r.stb = 1'b0;
        r.cyc = 1'b0;
        o_req <= r;
    endtask
endmodule

// >>> test/sbs_slave_bench.sv
/*
 * sbs_slave_bench: self-checking bench, design against a queue model.
 * assumes: sbs_master_model drives the bus; the bench drives resets and stream side.
 */
`timescale 1ns/1ps

module sbs_slave_bench
    import sbs_pkg::*;
;
    logic                i_ref_clk;
    logic                i_rst;
    logic                i_bus_rst;
    logic                i_priv_only;
    logic                i_stream_ready;
    sbs_req_type         bus_req;
    sbs_rsp_type         bus_rsp;
    logic [DAT_W-1:0]    o_stream_data;
    logic                o_stream_last;
    logic                o_stream_valid;
    logic [STREAM_W-1:0] exp_q[$];
    logic [9:0]          r;
    int                  failures;
    int                  n_checks;
    int                  seed;
    int                  n_err;
    int                  n_xfer;
    int                  cycles = 0;

    sbs_slave DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus_rst(i_bus_rst), .i_bus(bus_req), .o_bus(bus_rsp),
        .i_priv_only(i_priv_only), .o_stream_data(o_stream_data), .o_stream_last(o_stream_last),
        .o_stream_valid(o_stream_valid), .i_stream_ready(i_stream_ready));
    sbs_master_model mst (.i_ref_clk(i_ref_clk), .o_req(bus_req), .i_rsp(bus_rsp));

    // 100 MHz clock
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // hang guard
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_term(input sbs_term_type got, input sbs_term_type exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [STREAM_W-1:0] got, input logic [STREAM_W-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // status word expected from the model
    function automatic logic [DAT_W-1:0] status();
        logic [4:0] c;
        c = 5'(exp_q.size());
        return {16'(n_xfer), 8'(n_err), 1'b0, c == 5'h0, c == 5'h10, c};
    endfunction

    // one bus transfer, judged by the model
    task automatic xfer(input logic we, input logic [ADR_HI:ADR_LO] adr, input logic [SEL_W-1:0] sel,
                        input logic [TGA_W-1:0] tga);
        sbs_term_type     exp_t;
        sbs_term_type     got_t;
        logic [DAT_W-1:0] d;
        logic [DAT_W-1:0] rd;
        logic [TGC_W-1:0] tc;
        d  = DAT_W'($random(seed));
        tc = TGC_W'($random(seed));
        mst.run(we, adr, d, sel, tga, tc, got_t, rd);
        if (we ? (adr != ADR_DATA || sel != SEL_ALL || (i_priv_only && !tga[TGA_PRIV_BIT])) : adr != ADR_STATUS)
            exp_t = TERM_ERR;
        else if (we && exp_q.size() == FIFO_DEPTH)
            exp_t = TERM_RTY;
        else
            exp_t = TERM_ACK;
        chk_term(got_t, exp_t);
        if (exp_t == TERM_ERR)
            n_err++;
        else if (exp_t == TERM_ACK && !we)
            chk_word({1'b0, rd}, {1'b0, status()});
        else if (exp_t == TERM_ACK)
        begin
            exp_q.push_back({tc[TGC_LAST_BIT], d});
            n_xfer++;
        end
    endtask

    // pop with a randomly stalling consumer until the model is empty
    task automatic drain();
        while (exp_q.size() > 0)
        begin
            @(posedge i_ref_clk);
            if (o_stream_valid === 1'b1 && i_stream_ready === 1'b1)
                chk_word({o_stream_last, o_stream_data}, exp_q.pop_front());
            i_stream_ready <= exp_q.size() > 0 ? 1'($random(seed)) : 1'b0;
        end
    endtask

    // main sequence
    initial
    begin
        seed           = 32'hfc7c;
        failures       = 0;
        n_checks       = 0;
        n_err          = 0;
        n_xfer         = 0;
        i_rst          = 1'b1;
        i_bus_rst      = 1'b1;
        i_priv_only    = 1'b0;
        i_stream_ready = 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_rst       <= 1'b0;
        i_bus_rst   <= 1'b0;
        xfer(1'b0, ADR_STATUS, SEL_ALL, 2'h0);
        i_priv_only <= 1'b1;
        xfer(1'b1, ADR_STATUS, SEL_ALL, 2'h1);
        xfer(1'b1, ADR_DATA, 4'h3, 2'h1);
        xfer(1'b1, ADR_DATA, SEL_ALL, 2'h0);
        xfer(1'b0, ADR_DATA, SEL_ALL, 2'h0);
        repeat (FIFO_DEPTH + 1) xfer(1'b1, ADR_DATA, SEL_ALL, 2'h1);
        xfer(1'b0, ADR_STATUS, SEL_ALL, 2'h0);
        drain();
        repeat (24)
        begin
            r = 10'($random(seed));
            i_priv_only <= r[3];
            xfer(r[0], {29'h0, r[1]}, r[2] ? SEL_ALL : r[7:4], r[9:8]);
        end
        xfer(1'b0, ADR_STATUS, SEL_ALL, 2'h0);
        drain();
        repeat (3) xfer(1'b1, ADR_DATA, SEL_ALL, 2'h1);
        i_bus_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_bus_rst <= 1'b0;
        exp_q.delete();
        n_err  = 0;
        n_xfer = 0;
        xfer(1'b0, ADR_STATUS, SEL_ALL, 2'h0);
        stop_test();
    end
endmodule
